// File: logic/dmi_diag_map.sv
// dmi_diag_map: diagnostic register map with soft control and status.
// assumes measurement words, fault and signal-loss levels arrive
// synchronous to mclk; the host clocks the two-wire bus.
`timescale 1ns/1ns

module dmi_diag_map
  import dmi_pkg::*;
#(
  parameter int unsigned SERIAL_READY_CYC = SERIAL_CYC,
  parameter int unsigned DATA_READY_CYC   = DATA_CYC,
  parameter int unsigned TX_INIT_CYC      = INIT_CYC,
  parameter int unsigned POWER_STABLE_CYC = POWER_CYC
)
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output logic                          sdaOut,
  output logic                          sdaOe,
  input  wire logic [MEAS_N-1:0][15:0]  measIn,
  input  wire logic                     txFaultIn,
  input  wire logic                     receiveSignalLost,
  output logic                          txDisable,
  output logic                          rateSelect,
  output logic                          powerLevelHigh
);

  typedef struct packed {
    logic [7:0]               ptr;
    logic [MEAS_N-1:0][15:0]  snap;
    logic [7:0]               rdData;
    logic                     softOff;
    logic                     rateSel;
    logic                     pwrEn;
    logic                     offCmt;
    logic                     rateCmt;
    logic                     pwrCmt;
    logic                     faultLatch;
    logic                     losStat;
    logic [CNT_W-1:0]         porCnt;
    logic [CNT_W-1:0]         initCnt;
    logic [CNT_W-1:0]         pwrCnt;
    logic                     busReady;
    logic                     dataReady;
    logic                     initDone;
    logic                     pwrStable;
    logic                     txOff;
    logic                     rateOut;
    logic                     pwrOut;
  } dmi_map_s;

  localparam logic [CNT_W-1:0] SERIAL_LIM = CNT_W'(SERIAL_READY_CYC);
  localparam logic [CNT_W-1:0] DATA_LIM   = CNT_W'(DATA_READY_CYC);
  localparam logic [CNT_W-1:0] INIT_LIM   = CNT_W'(TX_INIT_CYC);
  localparam logic [CNT_W-1:0] POWER_LIM  = CNT_W'(POWER_STABLE_CYC);

  dmi_map_s   map_reg;
  dmi_map_s   map_next;
  dmi_link_if lnk ();

  // byte seen by the host at the current pointer
  function automatic logic [7:0] read_byte(input dmi_map_s s,
                                           input logic diag);
    logic [7:0]  rel;
    logic [15:0] word;
    rel  = 8'(s.ptr - REG_MEAS_FIRST);
    word = s.snap[rel[3:1]];
    read_byte = 8'h00;
    if (!diag) begin
      case (s.ptr)
        REG_MON_TYPE: read_byte = MON_TYPE_VAL;
        REG_CAPS:     read_byte = CAPS_VAL;
        REG_REV:      read_byte = REV_VAL;
        REG_XSUM:     read_byte = XSUM_VAL;
        default:      read_byte = 8'h00;
      endcase
    end else if (s.ptr >= REG_MEAS_FIRST && s.ptr <= REG_MEAS_LAST) begin
      // high byte at the even location; words pass through untouched,
      // so any threshold comparison shares this exact encoding
      read_byte = rel[0] ? word[7:0] : word[15:8];
    end else if (s.ptr == REG_CTRL) begin
      read_byte                = 8'h00;
      read_byte[CTRL_SOFT_OFF] = s.softOff;
      read_byte[CTRL_RATE]     = s.rateSel;
      read_byte[CTRL_FAULT]    = s.faultLatch & CAPS_VAL[CAP_SOFT_FAULT];
      read_byte[CTRL_LOS]      = s.losStat;
      read_byte[CTRL_READY]    = s.dataReady;
    end else if (s.ptr == REG_PWR) begin
      read_byte             = 8'h00;
      read_byte[PWR_EN]     = s.pwrEn;
      read_byte[PWR_STABLE] = s.pwrStable;
    end
  endfunction : read_byte

  // serial target: address match, shifting and acknowledge
  dmi_i2c_target u_target (
    .mclk  (mclk),
    .rst_n (rst_n),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .sdaOe (sdaOe),
    .lnk   (lnk.engine)
  );

  // next-state logic for pointer, controls, status and timers
  always_comb begin
    map_next = map_reg;

    // pointer: first written byte loads it, every later byte advances it
    if (lnk.wrByte) begin
      if (lnk.wrFirst) begin
        map_next.ptr = lnk.wrData;
      end else begin
        if (lnk.devSel && map_reg.ptr == REG_CTRL) begin
          map_next.softOff = lnk.wrData[CTRL_SOFT_OFF];
          map_next.rateSel = lnk.wrData[CTRL_RATE];
        end
        if (lnk.devSel && map_reg.ptr == REG_PWR) begin
          map_next.pwrEn = lnk.wrData[PWR_EN];
        end
        map_next.ptr = map_reg.ptr + 8'h01;
      end
    end else if (lnk.rdNext) begin
      map_next.ptr = map_reg.ptr + 8'h01;
    end

    // freeze all words at the read address so a word never tears
    if (lnk.rdStart) begin
      map_next.snap = measIn;
    end
    map_next.rdData = read_byte(map_reg, lnk.devSel);

    // written controls take effect only once the write is closed;
    // stored bits stay readable whatever the capability says
    if (lnk.stopSeen) begin
      map_next.offCmt  = map_reg.softOff;
      map_next.rateCmt = map_reg.rateSel;
      map_next.pwrCmt  = map_reg.pwrEn;
      // releasing soft off clears a latched fault and re-inits
      if (CAPS_VAL[CAP_SOFT_OFF] && map_reg.offCmt && !map_reg.softOff
          && map_reg.faultLatch) begin
        map_next.faultLatch = 1'b0;
        map_next.initDone   = 1'b0;
        map_next.initCnt    = '0;
      end
    end

    // a fault in the clearing cycle wins over the clear
    if (txFaultIn) begin
      map_next.faultLatch = 1'b1;
    end
    map_next.losStat = receiveSignalLost & CAPS_VAL[CAP_SOFT_LOS];

    // power-on count saturates at the data-ready limit
    if (map_reg.porCnt < DATA_LIM) begin
      map_next.porCnt = map_reg.porCnt + 1'b1;
    end
    map_next.busReady  = map_reg.porCnt >= SERIAL_LIM;
    map_next.dataReady = map_reg.porCnt >= DATA_LIM;

    // transmitter held dark until its init time has run
    if (!map_reg.initDone) begin
      if (map_reg.initCnt >= INIT_LIM) begin
        map_next.initDone = 1'b1;
      end else begin
        map_next.initCnt = map_reg.initCnt + 1'b1;
      end
    end

    // higher power level settles before it is reported stable
    if (!map_reg.pwrCmt) begin
      map_next.pwrCnt    = '0;
      map_next.pwrStable = 1'b0;
    end else if (map_reg.pwrCnt >= POWER_LIM) begin
      map_next.pwrStable = 1'b1;
    end else begin
      map_next.pwrCnt = map_reg.pwrCnt + 1'b1;
    end

    // outputs react within two cycles of the commit, far inside the 100 ms
    // window and the 1 ms bandwidth target, except txDisable after a fault-clearing release, which waits out the init time
    map_next.txOff   = ~map_reg.initDone |
                       (map_reg.offCmt & CAPS_VAL[CAP_SOFT_OFF]);
    map_next.rateOut = map_reg.rateCmt &
                       CAPS_VAL[CAP_SOFT_RATE];
    map_next.pwrOut  = map_reg.pwrCmt;
  end

  // state register; transmitter off from reset until init completes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      map_reg       <= '0;
      map_reg.ptr   <= PTR_RST;
      map_reg.txOff <= 1'b1;
    end else begin
      map_reg <= map_next;
    end
  end

  assign lnk.busReady   = map_reg.busReady;
  assign lnk.rdData     = map_reg.rdData;
  assign sdaOut         = 1'b0; // open drain: only ever pulls low
  assign txDisable      = map_reg.txOff;
  assign rateSelect     = map_reg.rateOut;
  assign powerLevelHigh = map_reg.pwrOut;

endmodule : dmi_diag_map

// File: logic/dmi_i2c_target.sv
// dmi_i2c_target: two-wire bus target, byte shifter and acknowledge.
// assumes scl/sda already synchronous to mclk; sda is open drain.
`timescale 1ns/1ns
module dmi_i2c_target
  import dmi_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOe,
  dmi_link_if.engine lnk
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WRITE, ST_WACK, ST_READ, ST_RACK
  } dmi_tgt_state_e;

  typedef struct packed {
    dmi_tgt_state_e st;
    logic           sclPrev;
    logic           sdaPrev;
    logic [7:0]     shift;
    logic [3:0]     bitCnt;
    logic           rw;
    logic           first;
    logic           oe;
    logic           devSel;
    logic           wrByte;
    logic           rdStart;
    logic           rdNext;
    logic           stopSeen;
  } dmi_tgt_s;

  dmi_tgt_s tgt_reg;
  dmi_tgt_s tgt_next;
  logic     sclRise;
  logic     sclFall;
  logic     startCond;
  logic     stopCond;

  // 200 samples per bit at 100 kHz, 50 at 400 kHz: edges never missed
  assign sclRise   = sclIn & ~tgt_reg.sclPrev;
  assign sclFall   = ~sclIn & tgt_reg.sclPrev;
  assign startCond = sclIn & tgt_reg.sclPrev & tgt_reg.sdaPrev & ~sdaIn;
  assign stopCond  = sclIn & tgt_reg.sclPrev & ~tgt_reg.sdaPrev & sdaIn;

  // protocol sequencing; sda only changes while scl is low
  always_comb begin
    tgt_next          = tgt_reg;
    tgt_next.wrByte   = 1'b0;
    tgt_next.rdStart  = 1'b0;
    tgt_next.rdNext   = 1'b0;
    tgt_next.stopSeen = 1'b0;
    tgt_next.sclPrev  = sclIn;
    tgt_next.sdaPrev  = sdaIn;
    if (stopCond) begin
      tgt_next.st       = ST_IDLE;
      tgt_next.oe       = 1'b0;
      tgt_next.stopSeen = 1'b1;
    end else if (startCond) begin
      // no start is honoured until the bus is declared ready
      tgt_next.st     = lnk.busReady ? ST_ADDR : ST_IDLE;
      tgt_next.bitCnt = 4'h0;
      tgt_next.oe     = 1'b0;
    end else begin
      case (tgt_reg.st)
        ST_ADDR, ST_WRITE: begin
          if (sclRise && tgt_reg.bitCnt < 4'h8) begin
            tgt_next.shift  = {tgt_reg.shift[6:0], sdaIn};
            tgt_next.bitCnt = tgt_reg.bitCnt + 4'h1;
          end else if (sclFall && tgt_reg.bitCnt == 4'h8) begin
            if (tgt_reg.st == ST_WRITE) begin
              tgt_next.oe     = 1'b1;
              tgt_next.st     = ST_WACK;
              tgt_next.wrByte = 1'b1;
            end else if (tgt_reg.shift[7:1] == ADDR_ID ||
                         tgt_reg.shift[7:1] == ADDR_DIAG) begin
              tgt_next.oe      = 1'b1;
              tgt_next.st      = ST_AACK;
              tgt_next.rw      = tgt_reg.shift[0];
              tgt_next.devSel  = tgt_reg.shift[1];
              tgt_next.first   = 1'b1;
              tgt_next.rdStart = tgt_reg.shift[0];
            end else begin
              tgt_next.st = ST_IDLE;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (sclFall) begin
            if (tgt_reg.st == ST_AACK && tgt_reg.rw) begin
              tgt_next.oe     = ~lnk.rdData[7];
              tgt_next.shift  = {lnk.rdData[6:0], 1'b1};
              tgt_next.bitCnt = 4'h1;
              tgt_next.rdNext = 1'b1;
              tgt_next.st     = ST_READ;
            end else begin
              tgt_next.oe     = 1'b0;
              tgt_next.st     = ST_WRITE;
              tgt_next.bitCnt = 4'h0;
              tgt_next.first  = (tgt_reg.st == ST_AACK);
            end
          end
        end
        ST_READ: begin
          if (sclFall) begin
            if (tgt_reg.bitCnt == 4'h8) begin
              tgt_next.oe = 1'b0;
              tgt_next.st = ST_RACK;
            end else begin
              tgt_next.oe     = ~tgt_reg.shift[7];
              tgt_next.shift  = {tgt_reg.shift[6:0], 1'b1};
              tgt_next.bitCnt = tgt_reg.bitCnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          // a nack from the host ends the read; it then sends stop
          if (sclRise && sdaIn) begin
            tgt_next.st = ST_IDLE;
          end else if (sclFall) begin
            tgt_next.oe     = ~lnk.rdData[7];
            tgt_next.shift  = {lnk.rdData[6:0], 1'b1};
            tgt_next.bitCnt = 4'h1;
            tgt_next.rdNext = 1'b1;
            tgt_next.st     = ST_READ;
          end
        end
        default: tgt_next.st = ST_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_reg         <= '0;
      tgt_reg.st      <= ST_IDLE;
      tgt_reg.sclPrev <= 1'b1;
      tgt_reg.sdaPrev <= 1'b1;
    end else begin
      tgt_reg <= tgt_next;
    end
  end

  assign sdaOe        = tgt_reg.oe;
  assign lnk.devSel   = tgt_reg.devSel;
  assign lnk.wrByte   = tgt_reg.wrByte;
  assign lnk.wrFirst  = tgt_reg.first;
  assign lnk.wrData   = tgt_reg.shift;
  assign lnk.rdStart  = tgt_reg.rdStart;
  assign lnk.rdNext   = tgt_reg.rdNext;
  assign lnk.stopSeen = tgt_reg.stopSeen;

endmodule : dmi_i2c_target

// File: shared/dmi_link_if.sv
// dmi_link_if: byte-level handshake between serial target and map.
// assumes both ends share mclk; every strobe is one cycle wide.
`timescale 1ns/1ns
interface dmi_link_if;
  logic       busReady;
  logic       devSel;
  logic       wrByte;
  logic       wrFirst;
  logic [7:0] wrData;
  logic       rdStart;
  logic       rdNext;
  logic [7:0] rdData;
  logic       stopSeen;

  modport engine (input busReady, input rdData, output devSel,
                  output wrByte, output wrFirst, output wrData,
                  output rdStart, output rdNext, output stopSeen);
  modport map    (output busReady, output rdData, input devSel,
                  input wrByte, input wrFirst, input wrData,
                  input rdStart, input rdNext, input stopSeen);
endinterface : dmi_link_if

// File: shared/dmi_pkg.sv
// dmi_pkg: constants shared by the diagnostic map and its serial target.
// assumes a single 20 MHz clock; counts are derived from times below.
package dmi_pkg;

  // clock rate and power-on / settle times
  localparam int unsigned CLK_KHZ     = 20000;
  localparam int unsigned T_SERIAL_MS = 300;
  localparam int unsigned T_DATA_MS   = 1000;
  localparam int unsigned T_INIT_MS   = 300;
  localparam int unsigned T_POWER_MS  = 300;
  localparam int unsigned SERIAL_CYC  = T_SERIAL_MS * CLK_KHZ;
  localparam int unsigned DATA_CYC    = T_DATA_MS * CLK_KHZ;
  localparam int unsigned INIT_CYC    = T_INIT_MS * CLK_KHZ;
  localparam int unsigned POWER_CYC   = T_POWER_MS * CLK_KHZ;
  localparam int unsigned CNT_W       = 25;

  // two-wire device addresses (7 bit)
  localparam logic [6:0] ADDR_ID   = 7'h50;
  localparam logic [6:0] ADDR_DIAG = 7'h51;

  // byte locations
  localparam logic [7:0] REG_MON_TYPE   = 8'h5c;
  localparam logic [7:0] REG_CAPS       = 8'h5d;
  localparam logic [7:0] REG_REV        = 8'h5e;
  localparam logic [7:0] REG_XSUM       = 8'h5f;
  localparam logic [7:0] REG_MEAS_FIRST = 8'h60;
  localparam logic [7:0] REG_MEAS_LAST  = 8'h6d;
  localparam logic [7:0] REG_CTRL       = 8'h6e;
  localparam logic [7:0] REG_PWR        = 8'h76;

  // capability bit positions
  localparam int CAP_FLAGS      = 7;
  localparam int CAP_SOFT_OFF   = 6;
  localparam int CAP_SOFT_FAULT = 5;
  localparam int CAP_SOFT_LOS   = 4;
  localparam int CAP_SOFT_RATE  = 3;
  localparam int CAP_APP_SEL    = 2;
  localparam int CAP_ALT_RATE   = 1;

  // control/status byte bit positions
  localparam int CTRL_SOFT_OFF = 6;
  localparam int CTRL_RATE     = 3;
  localparam int CTRL_FAULT    = 2;
  localparam int CTRL_LOS      = 1;
  localparam int CTRL_READY    = 0;
  localparam int PWR_EN        = 0;
  localparam int PWR_STABLE    = 1;
  localparam int MON_INTERNAL  = 5;
  localparam int MON_EXTERNAL  = 4;

  // fixed contents and reset values
  localparam logic [7:0] MON_TYPE_VAL = 8'h68;
  localparam logic [7:0] CAPS_VAL     = 8'h78;
  localparam logic [7:0] REV_VAL      = 8'h05;
  localparam logic [7:0] XSUM_VAL     =
    8'(MON_TYPE_VAL + CAPS_VAL + REV_VAL);
  localparam logic [7:0] PTR_RST      = 8'h00;
  localparam int unsigned MEAS_N      = 7;

endpackage : dmi_pkg

// File: sim/dmi_diag_map_monitor.sv
// dmi_diag_map_monitor: port-level checks on the diagnostic map.
// assumes sclIn/sdaIn are the resolved, mclk-synchronous bus levels.
`timescale 1ns/1ns
module dmi_diag_map_monitor
  import dmi_pkg::*;
#(
  parameter int unsigned SERIAL_READY_CYC = SERIAL_CYC,
  parameter int unsigned TX_INIT_CYC      = INIT_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOe,
  input wire logic txDisable,
  input wire logic rateSelect,
  input wire logic powerLevelHigh
);
  logic [31:0] upCnt;
  logic [3:0]  stopAge;
  logic        sclQ;
  logic        sdaQ;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // age since reset and since the last stop, both saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt   <= '0;
      stopAge <= 4'hf;
      sclQ    <= 1'b1;
      sdaQ    <= 1'b1;
    end else begin
      sclQ <= sclIn;
      sdaQ <= sdaIn;
      if (upCnt != 32'hffffffff) upCnt <= upCnt + 32'h1;
      if (sclIn && sclQ && sdaIn && !sdaQ) stopAge <= 4'h0;
      else if (stopAge != 4'hf) stopAge <= stopAge + 4'h1;
    end
  end

  a_reset_state: assert property ($rose(rst_n) |-> txDisable &&
    !rateSelect && !powerLevelHigh && !sdaOe)
    else $error("outputs wrong after reset");
  a_early_quiet: assert property (upCnt < SERIAL_READY_CYC |-> !sdaOe)
    else $error("bus answered before ready time");
  a_drive_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line changed while bus clock high");
  a_bit_stands: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("driven bit released too early");
  a_off_after_stop: assert property ($rose(txDisable) |->
    stopAge <= 4'h8) else $error("transmit off without a stop");
  a_rate_after_stop: assert property ($changed(rateSelect) |->
    stopAge <= 4'h8) else $error("bandwidth moved without a stop");
  a_power_after_stop: assert property ($changed(powerLevelHigh) |->
    stopAge <= 4'h8) else $error("power level moved without a stop");
  a_on_after_init: assert property ($fell(txDisable) |->
    upCnt >= TX_INIT_CYC) else $error("transmitter on before init");

  c_soft_off: cover property ($rose(txDisable));
  c_rate_on: cover property ($rose(rateSelect));
  c_power_on: cover property ($rose(powerLevelHigh));
endmodule : dmi_diag_map_monitor

bind dmi_diag_map dmi_diag_map_monitor #(
  .SERIAL_READY_CYC(SERIAL_READY_CYC),
  .TX_INIT_CYC     (TX_INIT_CYC)
) i_mon (
  .mclk          (mclk),
  .rst_n         (rst_n),
  .sclIn         (sclIn),
  .sdaIn         (sdaIn),
  .sdaOe         (sdaOe),
  .txDisable     (txDisable),
  .rateSelect    (rateSelect),
  .powerLevelHigh(powerLevelHigh)
);

// File: sim/dmi_diag_map_tb.sv
// dmi_diag_map_tb: self-checking bench for the diagnostic map.
// assumes shortened power-on counts; sda has a pull-up.
`timescale 1ns/1ns
module dmi_diag_map_tb
  import dmi_pkg::*;
;
  // init time longer than the 100-cycle tail of stopBit, so it can be seen
  localparam int TI = 200;
  logic                  mclk;
  logic                  rst_n;
  logic                  sclIn;
  logic                  sdaIn;
  logic                  sdaOut;
  logic                  sdaOe;
  logic                  sdaRel;
  logic [MEAS_N-1:0][15:0] measIn;
  logic                  txFaultIn;
  logic                  receiveSignalLost;
  logic                  txDisable;
  logic                  rateSelect;
  logic                  powerLevelHigh;
  logic [7:0]            rdBuf [4];
  int                    failCount;
  int                    checkCount;

  // open-drain line: low if either side pulls
  assign sdaIn = sdaRel & ~sdaOe;
  always #25 mclk = ~mclk;

  dmi_diag_map #(.SERIAL_READY_CYC(50), .DATA_READY_CYC(100),
    .TX_INIT_CYC(TI), .POWER_STABLE_CYC(30)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .measIn(measIn),
    .txFaultIn(txFaultIn), .receiveSignalLost(receiveSignalLost),
    .txDisable(txDisable), .rateSelect(rateSelect),
    .powerLevelHigh(powerLevelHigh));
  dmi_host_model #(.HALF(100)) i_host (.mclk(mclk), .sdaLine(sdaIn),
    .sclOut(sclIn), .sdaRel(sdaRel));

  task automatic reportAndStop();
    $display("checks %0d, mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : reportAndStop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk8

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : waitCyc

  task automatic send(input logic [7:0] b);
    logic a;
    i_host.putByte(b, a);
    chk8({7'h0, a}, 8'h01, "no ack");
  endtask : send

  task automatic wrReg(input logic [6:0] dev, input logic [7:0] p,
                       input logic [7:0] d);
    i_host.startBit();
    send({dev, 1'b0});
    send(p);
    send(d);
    i_host.stopBit();
  endtask : wrReg

  task automatic rdRegs(input logic [6:0] dev, input logic [7:0] p,
                        input int n);
    i_host.startBit();
    send({dev, 1'b0});
    send(p);
    i_host.restartBit();
    send({dev, 1'b1});
    for (int i = 0; i < n; i++) i_host.getByte(rdBuf[i], i == n - 1);
    i_host.stopBit();
  endtask : rdRegs

  // start right after reset must be ignored
  task automatic testEarly();
    logic a;
    i_host.startBit();
    i_host.putByte({ADDR_DIAG, 1'b0}, a);
    chk8({7'h0, a}, 8'h00, "early ack");
    chk8({7'h0, sdaOut}, 8'h00, "sda level");
    i_host.stopBit();
    $display("test early done");
  endtask : testEarly

  task automatic testIdArea();
    logic [7:0] caps;
    caps = 8'h0;
    caps[CAP_SOFT_OFF] = 1'b1;
    caps[CAP_SOFT_FAULT] = 1'b1;
    caps[CAP_SOFT_LOS] = 1'b1;
    caps[CAP_SOFT_RATE] = 1'b1;
    rdRegs(ADDR_ID, REG_MON_TYPE, 4);
    chk8(rdBuf[0] & 8'h30, 8'h20, "cal flags");
    chk8(rdBuf[1], caps, "capabilities");
    chk8(rdBuf[2], 8'h05, "revision");
    chk8(rdBuf[3], 8'(MON_TYPE_VAL + caps + 8'h05), "checksum");
    chk8({7'h0, txDisable}, 8'h00, "tx after init");
    $display("test id area done");
  endtask : testIdArea

  // off and bandwidth set together; readback plus ready bit
  task automatic testSoftCtrl();
    wrReg(ADDR_DIAG, REG_CTRL, 8'h48);
    waitCyc(5);
    chk8({7'h0, txDisable}, 8'h01, "soft off");
    chk8({7'h0, rateSelect}, 8'h01, "rate");
    rdRegs(ADDR_DIAG, REG_CTRL, 1);
    chk8(rdBuf[0], 8'h49, "ctrl readback");
    $display("test soft control done");
  endtask : testSoftCtrl

  // fault cleared by toggling soft off restarts the init delay
  task automatic testFaultLos();
    int n;
    txFaultIn = 1'b1;
    receiveSignalLost = 1'b1;
    waitCyc(4);
    rdRegs(ADDR_DIAG, REG_CTRL, 1);
    chk8(rdBuf[0], 8'h4f, "fault and loss");
    txFaultIn = 1'b0;
    receiveSignalLost = 1'b0;
    wrReg(ADDR_DIAG, REG_CTRL, 8'h08);
    n = 0;
    while (txDisable !== 1'b0 && n < TI - 90) begin
      waitCyc(1);
      n++;
    end
    if (n >= TI - 90) begin
      failCount++;
      $display("mismatch at %0t: transmitter stayed off", $time);
      reportAndStop();
    end
    // stopBit already spent 100 cycles after the stop was seen
    chk8(8'(n + 100 >= TI), 8'h01, "init restart");
    rdRegs(ADDR_DIAG, REG_CTRL, 1);
    chk8(rdBuf[0], 8'h09, "status cleared");
    $display("test fault and loss done");
  endtask : testFaultLos

  // word changes mid-read; both bytes must be the old sample
  task automatic testMeas();
    measIn[4] = 16'h1234;
    fork
      rdRegs(ADDR_DIAG, 8'h68, 2);
      begin
        // after the snapshot, before the low byte is loaded
        waitCyc(7000);
        measIn[4] = 16'habcd;
      end
    join
    chk8(rdBuf[0], 8'h12, "rx power high");
    chk8(rdBuf[1], 8'h34, "rx power low");
    $display("test measurement done");
  endtask : testMeas

  task automatic testPower();
    wrReg(ADDR_DIAG, REG_PWR, 8'h01);
    waitCyc(5);
    chk8({7'h0, powerLevelHigh}, 8'h01, "power enable");
    rdRegs(ADDR_DIAG, REG_PWR, 1);
    chk8(rdBuf[0], 8'h03, "power stable");
    $display("test power done");
  endtask : testPower

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    measIn = '0;
    txFaultIn = 1'b0;
    receiveSignalLost = 1'b0;
    failCount = 0;
    checkCount = 0;
    waitCyc(20);
    rst_n = 1'b1;
    testEarly();
    testIdArea();
    testSoftCtrl();
    testFaultLos();
    testMeas();
    testPower();
    reportAndStop();
  end
endmodule : dmi_diag_map_tb

// File: sim/dmi_host_model.sv
// dmi_host_model: two-wire bus host, bit- and byte-level tasks only.
// assumes the bench resolves sda as released-and-not-pulled.
`timescale 1ns/1ns
module dmi_host_model #(
  parameter int HALF = 100
)
(
  input  wire logic mclk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaRel
);
  // bus clock idles high outside frames; 100 cycles = 100 kHz
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt

  task automatic startBit();
    sdaRel = 1'b0;
    wt(HALF);
    sclOut = 1'b0;
    wt(HALF);
  endtask : startBit

  // repeated start from a low bus clock
  task automatic restartBit();
    sdaRel = 1'b1;
    wt(HALF);
    sclOut = 1'b1;
    wt(HALF);
    startBit();
  endtask : restartBit

  task automatic stopBit();
    sdaRel = 1'b0;
    wt(HALF);
    sclOut = 1'b1;
    wt(HALF);
    sdaRel = 1'b1;
    wt(HALF);
  endtask : stopBit

  // one clock pulse, data sampled mid-high
  task automatic clkBit(output logic s);
    wt(HALF);
    sclOut = 1'b1;
    wt(HALF / 2);
    s = sdaLine;
    wt(HALF / 2);
    sclOut = 1'b0;
  endtask : clkBit

  task automatic putByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sdaRel = b[i];
      clkBit(s);
    end
    sdaRel = 1'b1;
    clkBit(s);
    ack = !s;
  endtask : putByte

  // nack on the last byte ends the read
  task automatic getByte(output logic [7:0] b, input logic nack);
    logic s;
    sdaRel = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      clkBit(s);
      b[i] = s;
    end
    sdaRel = nack;
    clkBit(s);
  endtask : getByte
endmodule : dmi_host_model
